// [rtl/tape_intake_consts.svh]
// Constants of the tape control unit command intake: command and status word layout, timing.
// Assumes inclusion by the package and by every design file that needs a field position.
// What this block does
// - Bit 4 out, bit 5 in, bit 7 lockout
// - Bits 11-14 are drive instruction lines
// - Bits 15-21 one-hot select drives 1-7
// - Only writes, searches, transfers move data
// - Missing outbound flag: no data, no error
// - Missing inbound flag: no data, no error
// - Accepting a command makes unit Not Available
// - Stay Not Available during exchange and transfer
// - Commands while Not Available are ignored
// - Completion raises status-report interrupt
// - Status word presented with the interrupt
// - Input acknowledge returns unit to Available
// - Terminal lines recorded only without lockout
// - Status bits 0-2 abort, interrupt at once
`ifndef TAPE_INTAKE_CONSTS_SVH
`define TAPE_INTAKE_CONSTS_SVH
`define CMD_OUT_BIT      4
`define CMD_IN_BIT       5
`define CMD_LOCKOUT_BIT  7
`define CMD_INSTR_LSB    11
`define CMD_INSTR_MSB    14
`define CMD_SEL_LSB      15
`define CMD_SEL_MSB      21
`define ST_ABNORMAL      0
`define ST_NOT_READY     1
`define ST_SPECIAL       2
`define ST_DRIVE_ERR     3
`define ST_NO_RESP       4
`define ST_PARITY        5
`define ST_TIMING        6
`define ST_TERM_LSB      11
`define ST_TERM_MSB      14
`define ST_READY_LSB     23
`define ST_READY_MSB     29
`define RESP_TIMEOUT_NS  1000
`define CLK_PERIOD_NS    50
`define RESP_TIMEOUT_CYC ((`RESP_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_WRITE         4'h0
`define OP_XFER_TO_CPU   4'h8
`define OP_XFER_TO_DRV   4'hF
`endif

// [rtl/tape_intake_pkg.sv]
// Types of the tape control unit command intake.
// Assumes the constants header sits beside it in rtl/.
`include "tape_intake_consts.svh"
package tape_intake_pkg;
    typedef enum logic [4:0] {
        ST_AVAIL   = 5'h01,
        ST_EXCH    = 5'h02,
        ST_DECIDE  = 5'h04,
        ST_XFER    = 5'h08,
        ST_REPORT  = 5'h10
    } intake_state_t;

    typedef logic [29:0] word_t;

    // Search codes have their two low lines not both 0, with bits 3-2 at 0 or 2.
    function automatic logic needs_out(input logic [3:0] op);
        needs_out = (op == `OP_WRITE) || (op == `OP_XFER_TO_DRV) ||
                    ((op[1:0] != 2'h0) && (op[3:2] == 2'h0 || op[3:2] == 2'h2));
    endfunction
endpackage

// [rtl/status_gather.sv]
// Assembles the status-report word from the drive answers of one control exchange.
// Assumes the answer lines are valid in the cycle that capture_en is high.
`include "tape_intake_consts.svh"
module status_gather
    import tape_intake_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clear_en,
    input  wire logic        capture_en,
    input  wire logic        lockout,
    input  wire logic [6:0]  ready_all,
    input  wire logic        addr_ready,
    input  wire logic        addr_not_ready,
    input  wire logic        addr_error,
    input  wire logic [3:0]  term_wxyz,
    input  wire logic        xfer_parity,
    input  wire logic        xfer_timing,
    output logic      [29:0] status_q
);
    logic [29:0] status_d;
    logic [6:0]  ready_rev;

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            ready_rev[6 - i] = ready_all[i];
        end
        status_d = status_q;
        if (clear_en) begin
            status_d = 30'h0000_0000;
        end
        if (capture_en) begin
            status_d[`ST_READY_MSB:`ST_READY_LSB] = ready_rev;
            status_d[`ST_NOT_READY] = addr_not_ready;
            status_d[`ST_DRIVE_ERR] = addr_error;
            status_d[`ST_NO_RESP]   = ~addr_ready & ~addr_not_ready;
            if (!lockout) begin
                status_d[`ST_TERM_MSB:`ST_TERM_LSB] = term_wxyz;
                status_d[`ST_SPECIAL] = |term_wxyz;
            end
        end
        if (xfer_parity) begin
            status_d[`ST_PARITY] = 1'b1;
        end
        if (xfer_timing) begin
            status_d[`ST_TIMING] = 1'b1;
        end
        status_d[`ST_ABNORMAL] = |status_d[`ST_TIMING:`ST_DRIVE_ERR];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_q <= 30'h0000_0000;
        end else begin
            status_q <= status_d;
        end
    end
endmodule

// [rtl/tape_intake.sv]
// Command intake and availability of the tape control unit.
// Assumes the computer channel and drive answer lines are synchronous to core_clk.
`include "tape_intake_consts.svh"
module tape_intake
    import tape_intake_pkg::*;
#(
    parameter int RESP_WAIT = `RESP_TIMEOUT_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [29:0] cmd_word,
    input  wire logic        cmd_strobe,
    input  wire logic        input_ack,
    input  wire logic [6:0]  drive_ready,
    input  wire logic [6:0]  drive_not_ready,
    input  wire logic        drive_error,
    input  wire logic        drive_demand_out,
    input  wire logic [3:0]  drive_term_wxyz,
    input  wire logic        xfer_done,
    input  wire logic        xfer_parity_err,
    input  wire logic        xfer_timing_err,
    output logic             available_q,
    output logic             test_in_q,
    output logic             demand_clear_q,
    output logic      [6:0]  demand_in_q,
    output logic      [6:0]  drive_sel_q,
    output logic      [3:0]  drive_instr_q,
    output logic             instr_go_q,
    output logic             xfer_out_en_q,
    output logic             xfer_in_en_q,
    output logic             status_irq_q,
    output logic      [29:0] status_word_q
);
    intake_state_t state_q, state_d;
    logic [29:0]   cmd_q, cmd_d;
    logic [7:0]    wait_q, wait_d;
    logic          test_in_d, demand_clear_d, instr_go_d;
    logic          xout_d, xin_d, irq_d, avail_d;
    logic [6:0]    demand_d;
    logic [29:0]   status_q, word_d;
    logic          capture_en, clear_en;
    logic [3:0]    op;
    logic [6:0]    sel;
    logic          addr_ready, addr_nready, answered;

    assign op          = cmd_q[`CMD_INSTR_MSB:`CMD_INSTR_LSB];
    assign sel         = cmd_q[`CMD_SEL_MSB:`CMD_SEL_LSB];
    // A single select bit is trusted; several bits would merge their answers.
    assign addr_ready  = |(drive_ready & sel);
    assign addr_nready = |(drive_not_ready & sel);
    assign answered    = drive_demand_out | (|drive_term_wxyz) | drive_error;
    assign clear_en    = (state_q == ST_AVAIL) && cmd_strobe;
    assign capture_en  = (state_q == ST_EXCH) && (answered || wait_q == 8'h00);

    status_gather u_status (
        .core_clk       (core_clk),
        .rst            (rst),
        .clear_en       (clear_en),
        .capture_en     (capture_en),
        .lockout        (cmd_q[`CMD_LOCKOUT_BIT]),
        .ready_all      (drive_ready),
        .addr_ready     (addr_ready),
        .addr_not_ready (addr_nready),
        .addr_error     (drive_error),
        .term_wxyz      (drive_term_wxyz),
        .xfer_parity    ((state_q == ST_XFER) && xfer_parity_err),
        .xfer_timing    ((state_q == ST_XFER) && xfer_timing_err),
        .status_q       (status_q)
    );

    always_comb begin
        state_d        = state_q;
        cmd_d          = cmd_q;
        wait_d         = wait_q;
        test_in_d      = 1'b0;
        demand_clear_d = 1'b0;
        demand_d       = 7'h00;
        instr_go_d     = 1'b0;
        xout_d         = xfer_out_en_q;
        xin_d          = xfer_in_en_q;
        irq_d          = status_irq_q;
        avail_d        = available_q;
        word_d         = status_word_q;
        unique case (state_q)
            ST_AVAIL: begin
                if (cmd_strobe) begin
                    cmd_d          = cmd_word;
                    avail_d        = 1'b0;
                    test_in_d      = 1'b1;
                    demand_clear_d = 1'b1;
                    demand_d       = cmd_word[`CMD_SEL_MSB:`CMD_SEL_LSB];
                    wait_d         = RESP_WAIT[7:0];
                    state_d        = ST_EXCH;
                end
            end
            ST_EXCH: begin
                // Commands arriving here are dropped; nothing latches cmd_word outside ST_AVAIL.
                wait_d = wait_q - 8'h01;
                if (capture_en) begin
                    state_d = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (|status_q[`ST_SPECIAL:`ST_ABNORMAL]) begin
                    state_d = ST_REPORT;
                end else begin
                    instr_go_d = 1'b1;
                    // Inbound transfer without its flag simply moves nothing and flags no error.
                    // The outbound enable is never left on for a rewind, wind or read.
                    xout_d = cmd_q[`CMD_OUT_BIT] && needs_out(op);
                    xin_d  = cmd_q[`CMD_IN_BIT] && (op == `OP_XFER_TO_CPU);
                    if (xout_d || xin_d) begin
                        state_d = ST_XFER;
                    end else begin
                        state_d = ST_REPORT;
                    end
                end
            end
            ST_XFER: begin
                if (xfer_done) begin
                    xout_d  = 1'b0;
                    xin_d   = 1'b0;
                    state_d = ST_REPORT;
                end
            end
            ST_REPORT: begin
                if (!status_irq_q) begin
                    irq_d  = 1'b1;
                    word_d = status_q;
                end else if (input_ack) begin
                    irq_d   = 1'b0;
                    avail_d = 1'b1;
                    state_d = ST_AVAIL;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q        <= ST_AVAIL;
            cmd_q          <= 30'h0000_0000;
            wait_q         <= 8'h00;
            available_q    <= 1'b1;
            test_in_q      <= 1'b0;
            demand_clear_q <= 1'b0;
            demand_in_q    <= 7'h00;
            drive_sel_q    <= 7'h00;
            drive_instr_q  <= 4'h0;
            instr_go_q     <= 1'b0;
            xfer_out_en_q  <= 1'b0;
            xfer_in_en_q   <= 1'b0;
            status_irq_q   <= 1'b0;
            status_word_q  <= 30'h0000_0000;
        end else begin
            state_q        <= state_d;
            cmd_q          <= cmd_d;
            wait_q         <= wait_d;
            available_q    <= avail_d;
            test_in_q      <= test_in_d;
            demand_clear_q <= demand_clear_d;
            demand_in_q    <= demand_d;
            drive_sel_q    <= cmd_d[`CMD_SEL_MSB:`CMD_SEL_LSB];
            drive_instr_q  <= cmd_d[`CMD_INSTR_MSB:`CMD_INSTR_LSB];
            instr_go_q     <= instr_go_d;
            xfer_out_en_q  <= xout_d;
            xfer_in_en_q   <= xin_d;
            status_irq_q   <= irq_d;
            status_word_q  <= word_d;
        end
    end
endmodule

// [dv/tape_intake_assertions.sv]
// Concurrent checks on the ports of the tape control unit command intake.
// Assumes one clock domain and a synchronous active-high reset.
module tape_intake_assertions
    import tape_intake_pkg::*;
#(
    parameter int RESP_WAIT = 3
)
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [29:0] cmd_word,
    input wire logic        cmd_strobe,
    input wire logic        input_ack,
    input wire logic [6:0]  drive_not_ready,
    input wire logic        available_q,
    input wire logic        test_in_q,
    input wire logic        demand_clear_q,
    input wire logic [6:0]  demand_in_q,
    input wire logic [6:0]  drive_sel_q,
    input wire logic [3:0]  drive_instr_q,
    input wire logic        instr_go_q,
    input wire logic        xfer_out_en_q,
    input wire logic        xfer_in_en_q,
    input wire logic        status_irq_q,
    input wire logic [29:0] status_word_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_take;
        cmd_strobe && available_q;
    endsequence
    // The abort walk starts from an accepted command that met a not-ready answer.
    sequence s_not_ready;
        s_take ##1 (|(drive_not_ready & demand_in_q));
    endsequence
    AST_LEAVE: assert property (s_take |=> !available_q && test_in_q && demand_clear_q)
        else $error("Accepted command did not leave the available state.");
    AST_SELECT: assert property (s_take |=> demand_in_q == $past(cmd_word[21:15])
        && drive_sel_q == $past(cmd_word[21:15])) else $error("Drive select not taken from the command.");
    AST_INSTR: assert property (s_take |=> drive_instr_q == $past(cmd_word[14:11]))
        else $error("Drive instruction not taken from the command.");
    AST_IGNORE: assert property (cmd_strobe && !available_q |=> !test_in_q && $stable(drive_sel_q))
        else $error("Command taken while not available.");
    AST_BUSY: assert property (status_irq_q || xfer_out_en_q || xfer_in_en_q |-> !available_q)
        else $error("Available while still engaged.");
    AST_HOLD: assert property (status_irq_q && !input_ack |=> status_irq_q && $stable(status_word_q))
        else $error("Interrupt or status word changed before acknowledge.");
    AST_RELEASE: assert property (status_irq_q && input_ack |=> !status_irq_q && available_q)
        else $error("Acknowledge did not restore the available state.");
    AST_ABORT: assert property (s_not_ready |-> !instr_go_q [*3] ##1 (status_irq_q && status_word_q[1]))
        else $error("Not-ready answer did not abort with an interrupt.");
    AST_SUMMARY: assert property ($rose(status_irq_q) |-> status_word_q[0] == (|status_word_q[6:3])
        && status_word_q[2] == (|status_word_q[14:11])) else $error("Summary status bits inconsistent.");
    AST_XFER_OP: assert property (xfer_in_en_q |-> drive_instr_q == 4'h8)
        else $error("Inbound transfer enabled for a wrong instruction.");
endmodule

bind tape_intake tape_intake_assertions #(.RESP_WAIT(RESP_WAIT)) chk_u (.core_clk, .rst, .cmd_word,
    .cmd_strobe, .input_ack, .drive_not_ready, .available_q, .test_in_q, .demand_clear_q, .demand_in_q,
    .drive_sel_q, .drive_instr_q, .instr_go_q, .xfer_out_en_q, .xfer_in_en_q, .status_irq_q, .status_word_q);

// [dv/tape_drive_model.sv]
// Behavioural set of seven tape drives answering the control exchange and running transfers.
// Assumes demand_in_q is a one-cycle pulse and the transfer enables are levels.
module tape_drive_model #(
    parameter logic [6:0] READY_SET = 7'h7F
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic [6:0] demand_in_q,
    input  wire logic       xfer_out_en_q,
    input  wire logic       xfer_in_en_q,
    output logic      [6:0] drive_ready,
    output logic      [6:0] drive_not_ready,
    output logic            drive_error,
    output logic            drive_demand_out,
    output logic      [3:0] drive_term_wxyz,
    output logic            xfer_done
);
    logic       answer;
    logic [2:0] beat_q;
    logic [2:0] beat_d;
    // Answers are pulses during the demand only, so no stale level can be captured later.
    // Mode 0 is normal, 1 addressed drive not ready, 2 terminal line W, 3 drive error.
    assign answer = |demand_in_q;
    assign drive_ready = answer ? (READY_SET & ~((mode == 2'h1) ? demand_in_q : 7'h00)) : 7'h00;
    assign drive_not_ready = answer ? ~drive_ready : 7'h00;
    assign drive_error = answer && (mode == 2'h3);
    assign drive_demand_out = answer && !mode[1];
    assign drive_term_wxyz = (answer && mode == 2'h2) ? 4'h8 : 4'h0;
    always_comb begin
        beat_d = (xfer_out_en_q || xfer_in_en_q) ? beat_q + 3'h1 : 3'h0;
    end
    assign xfer_done = (beat_q == 3'h3);
    always_ff @(posedge core_clk) begin
        beat_q <= rst ? 3'h0 : beat_d;
    end
endmodule

// [dv/tb_tape_intake.sv]
// Self-checking bench of the tape control unit command intake.
// Assumes the drive model in dv/ and the design package in rtl/.
module tb_tape_intake import tape_intake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] RDY = 7'h55;
    localparam word_t      OUT = 30'h10, IN = 30'h20, LOCK = 30'h80;
    logic        core_clk = 1'b0, rst = 1'b1, cmd_strobe = 1'b0, input_ack = 1'b0;
    logic [1:0]  mode = 2'h0;
    word_t       cmd_word = 30'h0;
    logic [6:0]  drive_ready, drive_not_ready, demand_in_q, drive_sel_q;
    logic [3:0]  drive_term_wxyz, drive_instr_q;
    logic        drive_error, drive_demand_out, xfer_done, available_q, test_in_q, demand_clear_q;
    logic        instr_go_q, xfer_out_en_q, xfer_in_en_q, status_irq_q;
    logic [29:0] status_word_q;
    int          errors = 0, comparisons = 0;
    always #25 core_clk = ~core_clk;
    tape_intake #(.RESP_WAIT(3)) dut_u (.core_clk, .rst, .cmd_word, .cmd_strobe, .input_ack, .drive_ready,
        .drive_not_ready, .drive_error, .drive_demand_out, .drive_term_wxyz, .xfer_done, .xfer_parity_err(1'b0),
        .xfer_timing_err(1'b0), .available_q, .test_in_q, .demand_clear_q, .demand_in_q, .drive_sel_q,
        .drive_instr_q, .instr_go_q, .xfer_out_en_q, .xfer_in_en_q, .status_irq_q, .status_word_q);
    tape_drive_model #(.READY_SET(RDY)) drv_u (.core_clk, .rst, .mode, .demand_in_q, .xfer_out_en_q,
        .xfer_in_en_q, .drive_ready, .drive_not_ready, .drive_error, .drive_demand_out, .drive_term_wxyz,
        .xfer_done);
    task automatic check(input logic [29:0] seen, input logic [29:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [29:0] st(input logic [6:0] r, input logic [3:0] t, input logic [6:0] lo);
        st = {15'h0000, t, 4'h0, lo};
        for (int i = 0; i < 7; i++) begin
            st[29 - i] = r[i];
        end
    endfunction
    // A stray command follows each accepted one; it must leave no trace.
    task automatic issue(input word_t w, input logic [1:0] m, input logic [29:0] exp, input logic ex);
        int   n;
        logic sx;
        n = 0;
        sx = 1'b0;
        @(posedge core_clk);
        mode <= m;
        cmd_word <= w;
        cmd_strobe <= 1'b1;
        @(posedge core_clk);
        cmd_word <= w ^ 30'h03FF800;
        @(posedge core_clk);
        cmd_strobe <= 1'b0;
        #1;
        check(drive_sel_q, w[21:15]);
        check(drive_instr_q, w[14:11]);
        check(available_q, 1'b0);
        while (status_irq_q !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            sx |= xfer_out_en_q | xfer_in_en_q;
            n++;
        end
        check(status_word_q, exp);
        check(sx, ex);
        @(posedge core_clk);
        input_ack <= 1'b1;
        @(posedge core_clk);
        input_ack <= 1'b0;
        #1;
        check({status_irq_q, available_q}, 2'h1);
    endtask
    task automatic s_ops;
        word_t      fl [9];
        logic [3:0] op [9];
        logic [8:0] xp;
        fl = '{OUT, OUT, OUT, OUT, OUT, OUT, IN, 30'h0, OUT};
        op = '{4'h0, 4'h2, 4'hA, 4'h3, 4'hB, 4'hF, 4'h8, 4'h8, 4'hC};
        xp = 9'h07F;
        for (int i = 0; i < 9; i++) begin
            issue(fl[i] | (30'(op[i]) << 11) | (30'h8000 << (2 * (i % 4))), 2'h0, st(RDY, 4'h0, 7'h00), xp[i]);
        end
    endtask
    task automatic s_aborts;
        issue(OUT | 30'h20000, 2'h1, st(7'h51, 4'h0, 7'h02), 1'b0);
        issue(OUT | 30'h80000, 2'h3, st(RDY, 4'h0, 7'h09), 1'b0);
    endtask
    task automatic s_lockout;
        issue(30'h8000 | (30'hC << 11), 2'h2, st(RDY, 4'h8, 7'h04), 1'b0);
        issue(LOCK | 30'h8000 | (30'hC << 11), 2'h2, st(RDY, 4'h0, 7'h00), 1'b0);
    endtask
    task automatic conclude;
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        s_ops;
        s_aborts;
        s_lockout;
        conclude;
    end
    // About 140 cycles are needed; the limit leaves a wide margin.
    initial begin
        #200000;
        errors++;
        conclude;
    end
endmodule
